/* ump_port.sv */
// User master port: takes user requests and runs them on the system bus side.
// Assumes a system bus arbiter that grants sb_req and a slave that pulses sb_done per beat.
`timescale 1ns/10ps
module ump_port #(
  parameter bit ASYNC_MODE = 1'b0,
  parameter logic [1:0] PRIORITY = ump_pkg::PRIO_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // User side
  ump_if.port mp,
  // System bus request and arbitration
  output logic sb_req,
  output logic [1:0] sb_prio,
  output logic sb_lock,
  input wire logic sb_gnt,
  input wire logic sb_lost,
  // System bus transfer
  output logic sb_valid,
  output ump_pkg::ump_addr_t sb_addr,
  output logic sb_write,
  output logic [1:0] sb_size,
  output ump_pkg::ump_word_t sb_wdata,
  input wire logic sb_done,
  input wire ump_pkg::ump_word_t sb_rdata,
  input wire logic sb_err,
  input wire logic sb_retry
);
  import ump_pkg::*;

  ump_port_state_e state_reg, state_next;
  ump_word_t fifo_reg [BEATS];
  ump_word_t fifo_next [BEATS];
  ump_word_t rdata_reg, rdata_next;
  ump_addr_t addr_reg, addr_next;
  logic [1:0] size_reg, size_next;
  logic [1:0] beat_reg, beat_next;
  logic [CNT_W-1:0] low_reg, low_next;
  logic wr_reg, wr_next;
  logic burst_reg, burst_next;
  logic err_reg, err_next;
  logic retry_reg, retry_next;
  logic lock_reg, lock_next;
  logic ack;
  logic rst_all;
  logic [CNT_W-1:0] low_min;
  ump_addr_t wrap_mask;
  ump_addr_t step;

  // Either reset clears every control
  assign rst_all = !nrst || !mp.master_port_reset_n;

  // Acknowledge is high when idle, while seeking the lock, or presenting a burst read word
  assign ack = (state_reg == PS_IDLE) || (state_reg == PS_LOCKING) ||
               (state_reg == PS_DELIVER);
  assign mp.master_acknowledge = ack;
  assign mp.master_error_flag = err_reg;
  assign mp.master_retry_flag = retry_reg;
  assign mp.master_read_data = rdata_reg;

  // Async mode is modelled as extra crossing latency on one clock
  always_comb begin
    if (burst_reg && wr_reg) begin
      low_min = ASYNC_MODE ? LOW_BWR_ASYNC : LOW_BWR_SYNC;
    end else if (burst_reg) begin
      low_min = ASYNC_MODE ? LOW_BRD_ASYNC : LOW_BRD_SYNC;
    end else begin
      low_min = ASYNC_MODE ? LOW_SINGLE_ASYNC : LOW_SINGLE_SYNC;
    end
  end

  // Beat address wraps inside the four-beat block of the chosen size
  always_comb begin
    wrap_mask = ump_addr_t'((ADDR_W'(BEATS) << size_reg) - ADDR_W'(1));
    step = ump_addr_t'(ADDR_W'(beat_reg) << size_reg);
    sb_addr = (addr_reg & ~wrap_mask) | ((addr_reg + step) & wrap_mask);
  end

  // Bus side; the arbiter grants by this priority
  assign sb_prio = PRIORITY;
  assign sb_req = (state_reg == PS_BUSREQ) || (state_reg == PS_XFER) ||
                  (state_reg == PS_LOCKING) || lock_reg;
  assign sb_lock = lock_reg;
  assign sb_valid = (state_reg == PS_XFER) && sb_gnt;
  assign sb_write = wr_reg;
  assign sb_size = size_reg;
  assign sb_wdata = fifo_reg[beat_reg];

  always_comb begin
    state_next = state_reg;
    fifo_next = fifo_reg;
    rdata_next = rdata_reg;
    addr_next = addr_reg;
    size_next = size_reg;
    beat_next = beat_reg;
    wr_next = wr_reg;
    burst_next = burst_reg;
    err_next = err_reg;
    retry_next = retry_reg;
    lock_next = lock_reg;
    low_next = ack ? '0 : ((low_reg == '1) ? low_reg : low_reg + CNT_W'(1));
    unique case (state_reg)
      // A request with master_lock_request that arrives while the lock is sought is still taken, as ack is high
      PS_IDLE, PS_LOCKING: begin
        if (state_reg == PS_LOCKING && sb_gnt) begin
          lock_next = 1'b1;
          state_next = PS_IDLE;
        end
        if (mp.master_request) begin
          if ((lock_reg || state_reg == PS_LOCKING) && !mp.master_lock_request) begin
            lock_next = 1'b0;
            state_next = PS_IDLE;
          end else begin
            addr_next = mp.master_address;
            size_next = mp.master_transfer_size;
            wr_next = mp.master_write_read_select;
            burst_next = mp.master_burst_request;
            fifo_next[0] = mp.master_write_data;
            err_next = 1'b0;
            retry_next = 1'b0;
            beat_next = '0;
            if (mp.master_burst_request && mp.master_write_read_select) begin
              beat_next = 2'h1;
              state_next = PS_COLLECT;
            end else begin
              state_next = PS_BUSREQ;
            end
          end
        end else if (mp.master_lock_request && !lock_reg) begin
          state_next = PS_LOCKING;
        end
      end
      // Requests here feed burst beats; a dropped burst request sets the error flag and goes to PS_FLAG
      PS_COLLECT: begin
        if (!mp.master_burst_request) begin
          err_next = 1'b1;
          state_next = PS_FLAG;
        end else if (mp.master_request) begin
          fifo_next[beat_reg] = mp.master_write_data;
          if (beat_reg == BEAT_LAST) begin
            beat_next = '0;
            state_next = PS_BUSREQ;
          end else begin
            beat_next = beat_reg + 2'h1;
          end
        end
      end
      PS_BUSREQ: begin
        if (sb_gnt) begin
          state_next = PS_XFER;
        end
      end
      PS_XFER: begin
        if (sb_lost && burst_reg) begin
          retry_next = 1'b1;
          state_next = PS_FLAG;
        end else if (sb_done) begin
          if (sb_err || sb_retry) begin
            err_next = sb_err;
            retry_next = sb_retry;
            state_next = PS_FLAG;
          end else begin
            fifo_next[beat_reg] = sb_rdata;
            if (!burst_reg) begin
              if (!wr_reg) begin
                rdata_next = sb_rdata;
              end
              state_next = PS_FLAG;
            end else if (beat_reg == BEAT_LAST) begin
              beat_next = '0;
              if (wr_reg) begin
                state_next = PS_FLAG;
              end else begin
                rdata_next = fifo_reg[0];
                state_next = PS_FLAG;
              end
            end else begin
              beat_next = beat_reg + 2'h1;
            end
          end
        end
      end
      // Flags are already set here, so they lead acknowledge by at least a cycle
      PS_FLAG: begin
        // A saturated count would wrap to zero in the sum and never let the state go
        if ((low_reg == '1) || (low_reg + CNT_W'(1) >= low_min)) begin
          if (burst_reg && !wr_reg && !err_reg && !retry_reg) begin
            state_next = PS_DELIVER;
          end else begin
            state_next = PS_IDLE;
          end
        end
      end
      PS_DELIVER: begin
        if (mp.master_request) begin
          if (beat_reg == BEAT_LAST) begin
            state_next = PS_IDLE;
          end else begin
            beat_next = beat_reg + 2'h1;
            rdata_next = fifo_reg[beat_reg + 2'h1];
          end
        end else if (!mp.master_burst_request && beat_reg < 2'h2) begin
          err_next = 1'b1;
          state_next = PS_FLAG;
        end
      end
      default: begin
        state_next = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      state_reg <= PS_IDLE;
      for (int i = 0; i < BEATS; i++) begin
        fifo_reg[i] <= '0;
      end
      rdata_reg <= '0;
      addr_reg <= '0;
      size_reg <= SIZE_32;
      beat_reg <= '0;
      low_reg <= '0;
      wr_reg <= 1'b0;
      burst_reg <= 1'b0;
      err_reg <= 1'b0;
      retry_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fifo_reg <= fifo_next;
      rdata_reg <= rdata_next;
      addr_reg <= addr_next;
      size_reg <= size_next;
      beat_reg <= beat_next;
      low_reg <= low_next;
      wr_reg <= wr_next;
      burst_reg <= burst_next;
      err_reg <= err_next;
      retry_reg <= retry_next;
      lock_reg <= lock_next;
    end
  end
endmodule

/* ump_pkg.sv */
// Constants, types and state codes shared by both ends of the user master port.
// Assumes one clock, clk_sys, for both ends.
package ump_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int PAR_LSB = 32;
  localparam int BEATS = 4;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] LOW_SINGLE_SYNC = 4'h2;
  localparam logic [CNT_W-1:0] LOW_SINGLE_ASYNC = 4'h6;
  localparam logic [CNT_W-1:0] LOW_BWR_SYNC = 4'h6;
  localparam logic [CNT_W-1:0] LOW_BWR_ASYNC = 4'hA;
  localparam logic [CNT_W-1:0] LOW_BRD_SYNC = 4'h3;
  localparam logic [CNT_W-1:0] LOW_BRD_ASYNC = 4'h8;
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [1:0] PRIO_DEFAULT = 2'h1;
  localparam logic [1:0] BEAT_LAST = 2'h3;

  typedef logic [DATA_W-1:0] ump_word_t;
  typedef logic [ADDR_W-1:0] ump_addr_t;

  typedef enum logic [2:0] {
    PS_IDLE = 3'h0,
    PS_COLLECT = 3'h1,
    PS_BUSREQ = 3'h3,
    PS_XFER = 3'h2,
    PS_FLAG = 3'h6,
    PS_DELIVER = 3'h7,
    PS_LOCKING = 3'h5
  } ump_port_state_e;

  typedef enum logic [2:0] {
    US_IDLE = 3'h0,
    US_WAIT = 3'h1,
    US_BEATS = 3'h3,
    US_RDRAIN = 3'h2
  } ump_user_state_e;
endpackage

/* ump_if.sv */
// Pins between the user master port and the user fabric logic.
// Both ends run on clk_sys; no clocking block.
`timescale 1ns/10ps
interface ump_if;
  import ump_pkg::*;
  logic master_port_reset_n;
  ump_word_t master_write_data;
  ump_word_t master_read_data;
  ump_addr_t master_address;
  logic master_write_read_select;
  logic master_request;
  logic master_acknowledge;
  logic master_error_flag;
  logic master_retry_flag;
  logic master_lock_request;
  logic master_burst_request;
  logic [1:0] master_transfer_size;

  modport port (
    input master_port_reset_n, master_write_data, master_address, master_write_read_select,
    input master_request, master_lock_request, master_burst_request, master_transfer_size,
    output master_read_data, master_acknowledge, master_error_flag, master_retry_flag
  );
  modport user (
    output master_port_reset_n, master_write_data, master_address, master_write_read_select,
    output master_request, master_lock_request, master_burst_request, master_transfer_size,
    input master_read_data, master_acknowledge, master_error_flag, master_retry_flag
  );
endinterface

/* ump_user.sv */
// User fabric end: turns simple commands into master port pin activity.
// Assumes the port end on the same clk_sys; all pin outputs come from flops.
`timescale 1ns/10ps
module ump_user (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Port pins
  ump_if.user mu,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_burst,
  input wire ump_pkg::ump_addr_t cmd_addr,
  input wire logic [1:0] cmd_size,
  input wire logic [4*ump_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic lock_hold,
  // Response
  output logic rsp_valid,
  output logic rsp_err,
  output logic rsp_retry,
  output logic [4*ump_pkg::DATA_W-1:0] rsp_rdata
);
  import ump_pkg::*;

  ump_user_state_e state_reg, state_next;
  logic [4*DATA_W-1:0] wd_reg, wd_next;
  logic [4*DATA_W-1:0] rd_reg, rd_next;
  ump_word_t pin_wd_reg, pin_wd_next;
  ump_addr_t pin_addr_reg, pin_addr_next;
  logic [1:0] pin_size_reg, pin_size_next;
  logic [1:0] beat_reg, beat_next;
  logic req_reg, req_next;
  logic wr_reg, wr_next;
  logic burst_reg, burst_next;
  logic lock_reg, lock_next;
  logic rel_reg, rel_next;
  logic armed_reg, armed_next;
  logic rstn_reg;
  logic rv_reg, rv_next;
  logic re_reg, re_next;
  logic rr_reg, rr_next;

  // Narrow writes are copied to every lane; parity passes unchanged
  function automatic ump_word_t repl(input ump_word_t w, input logic [1:0] sz);
    ump_word_t r;
    r = w;
    if (sz == SIZE_8) begin
      r[PAR_LSB-1:0] = {4{w[7:0]}};
    end else if (sz == SIZE_16) begin
      r[PAR_LSB-1:0] = {2{w[15:0]}};
    end
    return r;
  endfunction

  assign mu.master_port_reset_n = rstn_reg;
  assign mu.master_request = req_reg;
  assign mu.master_write_data = pin_wd_reg;
  assign mu.master_address = pin_addr_reg;
  assign mu.master_transfer_size = pin_size_reg;
  assign mu.master_write_read_select = wr_reg;
  assign mu.master_burst_request = burst_reg;
  assign mu.master_lock_request = lock_reg;
  assign cmd_ready = (state_reg == US_IDLE) && mu.master_acknowledge && !rel_reg && !req_reg &&
                     !(lock_reg && !lock_hold);
  assign rsp_valid = rv_reg;
  assign rsp_err = re_reg;
  assign rsp_retry = rr_reg;
  assign rsp_rdata = rd_reg;

  always_comb begin
    state_next = state_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    pin_wd_next = pin_wd_reg;
    pin_addr_next = pin_addr_reg;
    pin_size_next = pin_size_reg;
    beat_next = beat_reg;
    req_next = 1'b0;
    wr_next = wr_reg;
    burst_next = burst_reg;
    lock_next = lock_reg;
    rel_next = rel_reg;
    armed_next = armed_reg || !mu.master_acknowledge;
    rv_next = 1'b0;
    re_next = re_reg;
    rr_next = rr_reg;
    unique case (state_reg)
      US_IDLE: begin
        if (mu.master_acknowledge && !req_reg) begin
          if (rel_reg) begin
            req_next = 1'b1;
            rel_next = 1'b0;
          end else if (lock_reg && !lock_hold) begin
            lock_next = 1'b0;
            rel_next = 1'b1;
          end else if (cmd_valid) begin
            req_next = 1'b1;
            wr_next = cmd_write;
            burst_next = cmd_burst;
            pin_addr_next = cmd_addr;
            pin_size_next = cmd_size;
            wd_next = cmd_wdata;
            pin_wd_next = repl(cmd_wdata[DATA_W-1:0], cmd_size);
            armed_next = 1'b0;
            beat_next = cmd_burst && cmd_write ? 2'h1 : 2'h0;
            state_next = cmd_burst ? (cmd_write ? US_BEATS : US_RDRAIN) : US_WAIT;
          end else begin
            lock_next = lock_hold;
          end
        end
      end
      US_BEATS: begin
        req_next = 1'b1;
        pin_wd_next = repl(wd_reg[beat_reg*DATA_W +: DATA_W], pin_size_reg);
        beat_next = beat_reg + 2'h1;
        if (beat_reg == BEAT_LAST) begin
          state_next = US_WAIT;
        end
      end
      US_WAIT: begin
        if (armed_reg && mu.master_acknowledge) begin
          rv_next = 1'b1;
          re_next = mu.master_error_flag;
          rr_next = mu.master_retry_flag;
          rd_next[DATA_W-1:0] = mu.master_read_data;
          burst_next = 1'b0;
          state_next = US_IDLE;
        end
      end
      // A word is taken only when no request is in flight, so none is read twice
      US_RDRAIN: begin
        if (armed_reg && mu.master_acknowledge && !req_reg) begin
          if (mu.master_error_flag || mu.master_retry_flag) begin
            rv_next = 1'b1;
            re_next = mu.master_error_flag;
            rr_next = mu.master_retry_flag;
            burst_next = 1'b0;
            state_next = US_IDLE;
          end else begin
            req_next = 1'b1;
            rd_next[beat_reg*DATA_W +: DATA_W] = mu.master_read_data;
            beat_next = beat_reg + 2'h1;
            if (beat_reg == BEAT_LAST) begin
              rv_next = 1'b1;
              re_next = 1'b0;
              rr_next = 1'b0;
              burst_next = 1'b0;
              state_next = US_IDLE;
            end
          end
        end
      end
      default: begin
        state_next = US_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= US_IDLE;
      wd_reg <= '0;
      rd_reg <= '0;
      pin_wd_reg <= '0;
      pin_addr_reg <= '0;
      pin_size_reg <= SIZE_32;
      beat_reg <= '0;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      burst_reg <= 1'b0;
      lock_reg <= 1'b0;
      rel_reg <= 1'b0;
      armed_reg <= 1'b0;
      rstn_reg <= 1'b0;
      rv_reg <= 1'b0;
      re_reg <= 1'b0;
      rr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      pin_wd_reg <= pin_wd_next;
      pin_addr_reg <= pin_addr_next;
      pin_size_reg <= pin_size_next;
      beat_reg <= beat_next;
      req_reg <= req_next;
      wr_reg <= wr_next;
      burst_reg <= burst_next;
      lock_reg <= lock_next;
      rel_reg <= rel_next;
      armed_reg <= armed_next;
      rstn_reg <= 1'b1;
      rv_reg <= rv_next;
      re_reg <= re_next;
      rr_reg <= rr_next;
    end
  end
endmodule

/* ump_chk_sva.sv */
// Checker on the pins between the user master port and the user fabric end.
// Assumes one clock, clk_sys, and synchronous reset nrst from the bench.
`timescale 1ns/10ps
module ump_chk_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pins
  input wire logic master_port_reset_n,
  input wire ump_pkg::ump_word_t master_read_data,
  input wire logic master_write_read_select,
  input wire logic master_request,
  input wire logic master_acknowledge,
  input wire logic master_error_flag,
  input wire logic master_retry_flag,
  input wire logic master_lock_request,
  input wire logic master_burst_request
);
  import ump_pkg::*;
  logic [2:0] words_reg;
  logic [2:0] words_next;
  logic locked_reg;
  logic locked_next;
  logic ack;
  logic take;
  // Word fetches of a burst read and lock releases are not new transfers
  assign ack = master_acknowledge;
  assign take = ack && master_request && words_reg == 3'h0 && !(locked_reg && !master_lock_request);
  always_comb begin
    words_next = words_reg;
    locked_next = locked_reg;
    if (ack && master_request && words_reg != 3'h0) begin
      words_next = words_reg - 3'h1;
    end else if (take && master_burst_request && !master_write_read_select) begin
      words_next = 3'h4;
    end
    if (ack && master_request && words_reg == 3'h0) begin
      locked_next = master_lock_request;
    end
    // An error or retry ends a burst read before its words are fetched
    if (ack && !master_request && (master_error_flag || master_retry_flag)) begin
      words_next = 3'h0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst || !master_port_reset_n) begin
      words_reg <= 3'h0;
      locked_reg <= 1'b0;
    end else begin
      words_reg <= words_next;
      locked_reg <= locked_next;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_single;
    take && !master_burst_request;
  endsequence
  sequence s_bwr;
    take && master_burst_request && master_write_read_select;
  endsequence
  sequence s_brd;
    take && master_burst_request && !master_write_read_select;
  endsequence
  property p_ack_drop;
    take |=> !ack;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack stayed high after request");
  property p_single_low;
    s_single |=> !ack [*2];
  endproperty
  a_single_low: assert property (p_single_low) else $error("single ack low too short");
  property p_bwr_low;
    s_bwr |=> !ack [*6];
  endproperty
  a_bwr_low: assert property (p_bwr_low) else $error("burst write ack low too short");
  property p_brd_low;
    s_brd |=> !ack [*3];
  endproperty
  a_brd_low: assert property (p_brd_low) else $error("burst read ack low too short");
  property p_flag_clear;
    $fell(ack) |-> !master_error_flag && !master_retry_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag set while ack drops");
  property p_flag_lead;
    $rose(ack) && (master_error_flag || master_retry_flag) |-> $past(master_error_flag || master_retry_flag);
  endproperty
  a_flag_lead: assert property (p_flag_lead) else $error("flag did not lead ack");
  property p_ack_hold;
    ack && !master_request |=> ack;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack fell without request");
  property p_rdata_hold;
    ack && !master_request && words_reg != 3'h0 |=> $stable(master_read_data);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read word moved without request");
  property p_reset;
    !master_port_reset_n |=> ack && !master_error_flag && !master_retry_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("port reset left controls set");
  property p_release;
    locked_reg && ack && master_request && !master_lock_request |=> ack;
  endproperty
  a_release: assert property (p_release) else $error("lock release started a transfer");
endmodule

/* tb_top.sv */
// Bench: user end and port joined by one pin interface, plus a second port driven directly.
// Assumes grant one cycle after request and a slave that answers each beat in one cycle.
`timescale 1ns/10ps
module tb_top;
  import ump_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_burst = 1'b0, lock_hold = 1'b0;
  ump_addr_t cmd_addr = '0;
  logic [1:0] cmd_size = 2'h0;
  logic [4*DATA_W-1:0] cmd_wdata = '0;
  logic [4*DATA_W-1:0] rsp_rdata;
  logic cmd_ready, rsp_valid, rsp_err, rsp_retry, sb_req, sb_lock, sb_valid, sb_write, b_req, b_valid;
  logic [1:0] sb_size;
  ump_addr_t sb_addr;
  ump_word_t sb_wdata;
  ump_word_t sb_rdata = '0;
  logic sb_gnt = 1'b0, sb_done = 1'b0, sb_err = 1'b0, sb_retry = 1'b0, err_mode = 1'b0, retry_mode = 1'b0;
  logic sb_lost = 1'b0, lost_mode = 1'b0;
  ump_addr_t wa_q[$];
  ump_word_t wd_q[$];
  int failures = 0, n_compared = 0, cyc = 0;
  ump_if bus_a();
  ump_if bus_b();
  ump_port u_ump_port (.clk_sys(clk_sys), .nrst(nrst), .mp(bus_a), .sb_req(sb_req), .sb_prio(), .sb_lock(sb_lock),
    .sb_gnt(sb_gnt), .sb_lost(sb_lost), .sb_valid(sb_valid), .sb_addr(sb_addr), .sb_write(sb_write),
    .sb_size(sb_size), .sb_wdata(sb_wdata), .sb_done(sb_done), .sb_rdata(sb_rdata), .sb_err(sb_err),
    .sb_retry(sb_retry));
  ump_user u_ump_user (.clk_sys(clk_sys), .nrst(nrst), .mu(bus_a), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_burst(cmd_burst), .cmd_addr(cmd_addr), .cmd_size(cmd_size),
    .cmd_wdata(cmd_wdata), .lock_hold(lock_hold), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_retry(rsp_retry), .rsp_rdata(rsp_rdata));
  // Second port: its user pins come from the bench, so it can see a burst dropped early
  ump_port #(.ASYNC_MODE(1'b1)) u2_ump_port (.clk_sys(clk_sys), .nrst(nrst), .mp(bus_b), .sb_req(b_req),
    .sb_prio(), .sb_lock(),
    .sb_gnt(b_req), .sb_lost(1'b0), .sb_valid(b_valid), .sb_addr(), .sb_write(), .sb_size(), .sb_wdata(),
    .sb_done(b_valid), .sb_rdata('0), .sb_err(1'b0), .sb_retry(1'b0));
  ump_chk_sva u_ump_chk_sva (.clk_sys(clk_sys), .nrst(nrst), .master_port_reset_n(bus_a.master_port_reset_n),
    .master_read_data(bus_a.master_read_data), .master_write_read_select(bus_a.master_write_read_select),
    .master_request(bus_a.master_request), .master_acknowledge(bus_a.master_acknowledge),
    .master_error_flag(bus_a.master_error_flag), .master_retry_flag(bus_a.master_retry_flag),
    .master_lock_request(bus_a.master_lock_request), .master_burst_request(bus_a.master_burst_request));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic ump_word_t rd_word(input ump_addr_t a);
    return {4'hA, a[13:0], a};
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [4*DATA_W-1:0] got, input logic [4*DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_cmd(input logic w, input logic b, input ump_addr_t a, input logic [1:0] s,
                        input logic [4*DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_burst <= b;
    cmd_addr <= a;
    cmd_size <= s;
    cmd_wdata <= wd;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 100);
    cmd_valid <= 1'b0;
    do @(posedge clk_sys); while (rsp_valid !== 1'b1 && ++n < 300);
    if (n >= 300) failures++;
  endtask
  // Slave answers one cycle after each beat; errors only when a scenario asks
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sb_gnt <= sb_req;
    sb_done <= sb_valid && !sb_done;
    sb_rdata <= rd_word(sb_addr);
    sb_err <= err_mode && sb_valid && !sb_done;
    sb_retry <= retry_mode && sb_valid && !sb_done;
    sb_lost <= lost_mode && sb_valid;
    if (sb_valid && !sb_done && sb_write) begin
      wa_q.push_back(sb_addr);
      wd_q.push_back(sb_wdata);
    end
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    logic [4*DATA_W-1:0] wd;
    ump_addr_t ea;
    logic e;
    int w;
    bus_b.master_port_reset_n = 1'b0;
    bus_b.master_write_data = '0;
    bus_b.master_address = '0;
    bus_b.master_write_read_select = 1'b0;
    bus_b.master_request = 1'b0;
    bus_b.master_lock_request = 1'b0;
    bus_b.master_burst_request = 1'b0;
    bus_b.master_transfer_size = SIZE_32;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    bus_b.master_port_reset_n <= 1'b1;
    do_cmd(1'b1, 1'b0, 18'h00004, SIZE_8, {108'h0, 36'h511111111});
    chk(wa_q.pop_front(), 18'h00004);
    chk(wd_q.pop_front(), 36'h511111111);
    do_cmd(1'b0, 1'b0, 18'h00004, SIZE_8, '0);
    chk(rsp_rdata[35:0], rd_word(18'h00004));
    $display("single access done");
    for (int i = 0; i < 4; i++) wd[36*i +: 36] = {4'(i), {4{8'(8'h11 * (i + 1))}}};
    do_cmd(1'b1, 1'b1, 18'h00004, SIZE_8, wd);
    chk(wa_q.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk(wa_q.pop_front(), 18'h00004 + i);
      chk(wd_q.pop_front(), wd[36*i +: 36]);
    end
    // Start in mid block so that the beat addresses wrap
    do_cmd(1'b0, 1'b1, 18'h00038, SIZE_32, '0);
    for (int i = 0; i < 4; i++) begin
      ea = (18'h00038 & ~18'hF) | ((18'h00038 + 18'(i << 2)) & 18'hF);
      chk(rsp_rdata[36*i +: 36], rd_word(ea));
    end
    $display("bursts done");
    for (int k = 0; k < 2; k++) begin
      err_mode = (k == 0);
      retry_mode = (k == 1);
      do_cmd(1'(k), 1'b0, 18'h00100, SIZE_32, '0);
      chk(rsp_err, k == 0);
      chk(rsp_retry, k == 1);
    end
    err_mode = 1'b0;
    retry_mode = 1'b0;
    void'(wa_q.pop_front());
    void'(wd_q.pop_front());
    lost_mode = 1'b1;
    do_cmd(1'b0, 1'b1, 18'h00040, SIZE_32, '0);
    chk(rsp_retry, 1'b1);
    lost_mode = 1'b0;
    $display("flags done");
    lock_hold <= 1'b1;
    do_cmd(1'b1, 1'b0, 18'h00200, SIZE_32, '0);
    do_cmd(1'b0, 1'b0, 18'h00200, SIZE_32, '0);
    chk(sb_lock, 1'b1);
    lock_hold <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk(sb_lock, 1'b0);
    $display("lock done");
    @(posedge clk_sys);
    bus_b.master_write_read_select <= 1'b1;
    bus_b.master_burst_request <= 1'b1;
    bus_b.master_request <= 1'b1;
    @(posedge clk_sys);
    bus_b.master_request <= 1'b0;
    @(posedge clk_sys);
    bus_b.master_request <= 1'b1;
    @(posedge clk_sys);
    bus_b.master_request <= 1'b0;
    bus_b.master_burst_request <= 1'b0;
    e = 1'b0;
    for (w = 0; w < 60 && bus_b.master_acknowledge !== 1'b1; w++) begin
      e = bus_b.master_error_flag;
      @(posedge clk_sys);
    end
    chk(e, 1'b1);
    chk(w + 1 >= LOW_BWR_ASYNC, 1'b1);
    chk(bus_b.master_acknowledge, 1'b1);
    $display("abort done");
    tally_and_finish();
  end
endmodule
